// >>> hw/slice_pointer_unit.v
// Working-register pointer pair with operand address resolution.
// Holds both slice pointers, their set-1 readback and the resolved operand.
// Assumes the decoder presents operands and write strobes synchronous to clk_i.
// Assumes page selection and set-2 routing are done downstream of op_addr_o.
`timescale 1ns/1ps
`include "slice_ptr_consts.vh"
module slice_pointer_unit (
  // Clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // Set-pointer instruction
  input wire [1:0] set_op_i,
  input wire [7:0] set_imm_i,
  // Set-1 register write/read (load, clear and other writes)
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rhit_o,
  // Operand resolution request
  input wire op_valid_i,
  input wire op_is_short_i,
  input wire [7:0] op_addr_i,
  input wire op_pair_i,
  // Resolved operand
  output reg op_valid_o,
  output reg [7:0] op_addr_o,
  output reg [7:0] op_addr_lo_o,
  output reg op_is_wreg_o,
  output reg op_set1_o,
  output reg op_bad_mode_o,
  // Pointer values
  output reg [7:0] first_slice_pointer_o,
  output reg [7:0] second_slice_pointer_o
);
  // Pointer storage and its next values
  reg [7:0] first_slice_pointer_r;
  reg [7:0] second_slice_pointer_r;
  reg [7:0] first_slice_pointer_nxt;
  reg [7:0] second_slice_pointer_nxt;
  // Register-bus strobes, decoded once for both paths
  wire first_wr;
  wire second_wr;
  wire first_rd;
  wire second_rd;
  // Operand classification and resolution
  wire is_wreg;
  wire [7:0] wreg_addr;
  wire [7:0] single_addr;
  wire [7:0] pair_base;
  // Next values of the registered outputs
  reg [7:0] reg_rdata_nxt;
  reg reg_rhit_nxt;
  reg op_valid_nxt;
  reg [7:0] op_addr_nxt;
  reg [7:0] op_addr_lo_nxt;
  reg op_is_wreg_nxt;
  reg op_set1_nxt;
  reg op_bad_mode_nxt;

  // Register address match used by both the write and read paths
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // Upper 64 bytes: set 1 by these modes, set 2 only by indirect or indexed
  function in_upper;
    input [7:0] a;
    begin
      in_upper = (a >= `COMMON_LO);
    end
  endfunction

  // Common working area, which software may name only in working form
  function in_common;
    input [7:0] a;
    begin
      in_common = (a >= `COMMON_LO) && (a <= `COMMON_HI);
    end
  endfunction

  // Even base of a pair; odd operands are rounded down, never up
  function [7:0] pair_even;
    input [7:0] a;
    begin
      pair_even = {a[`ADDR_MSB:`PAIR_HI_LSB], 1'h0};
    end
  endfunction

  // Strobes for the two pointer locations; other addresses are not ours
  assign first_wr = reg_wr_i & hit(reg_addr_i, `FIRST_PTR_ADDR);
  assign second_wr = reg_wr_i & hit(reg_addr_i, `SECOND_PTR_ADDR);
  assign first_rd = reg_rd_i & hit(reg_addr_i, `FIRST_PTR_ADDR);
  assign second_rd = reg_rd_i & hit(reg_addr_i, `SECOND_PTR_ADDR);

  // Short operands are always working refs; long ones if upper nibble is 1100B
  assign is_wreg = op_is_short_i | (op_addr_i[`ADDR_MSB:`NIB_LSB] == `WREG_NIBBLE);

  // Only the low nibble reaches the resolver, so a long prefix drops out here
  wreg_resolve u_resolve (
    .first_ptr_i(first_slice_pointer_r),
    .second_ptr_i(second_slice_pointer_r),
    .operand_i(op_addr_i[`OPND_SEL_BIT:`SLOT_LSB]),
    .addr_o(wreg_addr)
  );

  // Working refs take the slice address, plain refs pass straight through
  assign single_addr = is_wreg ? wreg_addr : op_addr_i;
  // Pair base forced even: even byte is MSB, odd follows with LSB
  assign pair_base = op_pair_i ? pair_even(single_addr) : single_addr;

  // Next pointer values; set instruction wins over a same-cycle register write
  always @* begin
    first_slice_pointer_nxt = first_slice_pointer_r;
    second_slice_pointer_nxt = second_slice_pointer_r;
    case (set_op_i)
      `SET_OP_BOTH: begin
        first_slice_pointer_nxt = set_imm_i;
        // Wraps modulo 256; software keeps the pair below the top slice
        second_slice_pointer_nxt = set_imm_i + `SLICE_STEP;
      end
      `SET_OP_FIRST: begin
        first_slice_pointer_nxt = set_imm_i;
      end
      `SET_OP_SECOND: begin
        second_slice_pointer_nxt = set_imm_i;
      end
      default: begin
        // Load, clear and any other write reach the pointers as plain bytes
        if (first_wr) begin
          first_slice_pointer_nxt = reg_wdata_i;
        end
        if (second_wr) begin
          second_slice_pointer_nxt = reg_wdata_i;
        end
      end
    endcase
  end

  // Pointer storage; all 8 bits kept so reads return what was written
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      first_slice_pointer_r <= `FIRST_PTR_RESET;
      second_slice_pointer_r <= `SECOND_PTR_RESET;
    end else begin
      first_slice_pointer_r <= first_slice_pointer_nxt;
      second_slice_pointer_r <= second_slice_pointer_nxt;
    end
  end

  // Read mux; a read in the cycle of a write still returns the old byte
  always @* begin
    reg_rhit_nxt = first_rd | second_rd;
    if (first_rd) begin
      reg_rdata_nxt = first_slice_pointer_r;
    end else if (second_rd) begin
      reg_rdata_nxt = second_slice_pointer_r;
    end else begin
      // Non-pointer addresses read as zero; their owners answer elsewhere
      reg_rdata_nxt = `CLEAR_BYTE;
    end
  end

  // Operand result; address fields follow the request even when it is idle
  always @* begin
    op_valid_nxt = op_valid_i;
    op_is_wreg_nxt = op_valid_i & is_wreg;
    // Final file address; page select lives outside, so the common area
    // answers the same on every page
    op_addr_nxt = pair_base;
    op_addr_lo_nxt = {pair_base[`ADDR_MSB:`PAIR_HI_LSB], 1'h1};
    // Working and plain refs resolving to C0H and above land in set 1, never set 2
    op_set1_nxt = op_valid_i & in_upper(single_addr);
    // Never raised: a long operand naming C0H-CFH has upper nibble 1100B, so is_wreg masks it
    op_bad_mode_nxt = op_valid_i & ~is_wreg & in_common(op_addr_i);
  end

  // Pointer copies for the datapath; same next value as the storage above
  // Kept apart from the storage so the copies can be placed near their users
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      first_slice_pointer_o <= `FIRST_PTR_RESET;
      second_slice_pointer_o <= `SECOND_PTR_RESET;
    end else begin
      first_slice_pointer_o <= first_slice_pointer_nxt;
      second_slice_pointer_o <= second_slice_pointer_nxt;
    end
  end

  // Readback, standing for one cycle after the read strobe
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= `CLEAR_BYTE;
      reg_rhit_o <= 1'h0;
    end else begin
      reg_rdata_o <= reg_rdata_nxt;
      reg_rhit_o <= reg_rhit_nxt;
    end
  end

  // Resolved operand, one cycle after the request edge; it uses the pointers
  // as they stood before any same-cycle update
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      op_valid_o <= 1'h0;
      op_addr_o <= `CLEAR_BYTE;
      op_addr_lo_o <= `CLEAR_BYTE;
      op_is_wreg_o <= 1'h0;
      op_set1_o <= 1'h0;
      op_bad_mode_o <= 1'h0;
    end else begin
      op_valid_o <= op_valid_nxt;
      op_addr_o <= op_addr_nxt;
      op_addr_lo_o <= op_addr_lo_nxt;
      op_is_wreg_o <= op_is_wreg_nxt;
      op_set1_o <= op_set1_nxt;
      op_bad_mode_o <= op_bad_mode_nxt;
    end
  end
endmodule

// >>> hw/wreg_resolve.v
// Combinational resolver of one working-register operand to a file address.
// Assumes pointer values are stable while the operand is presented.
`timescale 1ns/1ps
`include "slice_ptr_consts.vh"
module wreg_resolve (
  // Pointer values
  input wire [7:0] first_ptr_i,
  input wire [7:0] second_ptr_i,
  // Operand low nibble
  input wire [3:0] operand_i,
  // Resolved address
  output wire [7:0] addr_o
);
  wire [7:0] chosen;
  // Top operand bit picks pointer; slices may lie anywhere independently
  assign chosen = operand_i[`OPND_SEL_BIT] ? second_ptr_i : first_ptr_i;
  // Pointer low bits ignored here, only the slice base counts
  assign addr_o = {chosen[`ADDR_MSB:`SLICE_LSB], operand_i[`SLOT_MSB:`SLOT_LSB]};
endmodule

// >>> include/slice_ptr_consts.vh
// Constants for the working-register pointer addressing block.
// Assumes inclusion by bare name from hw/ design files.
// How it works
// - Two 8-bit slice pointers live at set-1 addresses D6H and D7H.
// - Reset sets first pointer to C0H and second to C8H.
// - Pointers change only on set-pointer instructions or register writes.
// - Combined set loads first with immediate, second with immediate plus 8.
// - Single set instructions load only their own pointer.
// - Working-register addressing never resolves into the set-2 space.
// - Operand top bit picks pointer: 0 first, 1 second.
// - Address is pointer bits 7..3 joined with operand bits 2..0.
// - Pointers are independent; slices may be non-contiguous or swapped.
// - Plain register addressing reaches every location except C0H-CFH and set 2.
// - Register pair: even address holds high byte, odd next holds low.
// - Common area works as working registers on every register page.
// - 8-bit operand with upper nibble 1100B is a working-register reference.
`ifndef SLICE_PTR_CONSTS_VH
`define SLICE_PTR_CONSTS_VH
`define FIRST_PTR_ADDR 8'hd6
`define SECOND_PTR_ADDR 8'hd7
`define FIRST_PTR_RESET 8'hc0
`define SECOND_PTR_RESET 8'hc8
`define SLICE_STEP 8'h08
`define WREG_NIBBLE 4'hc
`define COMMON_LO 8'hc0
`define COMMON_HI 8'hcf
`define SET_OP_NONE 2'h0
`define SET_OP_BOTH 2'h1
`define SET_OP_FIRST 2'h2
`define SET_OP_SECOND 2'h3
`define ADDR_MSB 7
`define NIB_LSB 4
`define SLICE_LSB 3
`define OPND_SEL_BIT 3
`define SLOT_MSB 2
`define SLOT_LSB 0
`define PAIR_HI_LSB 1
`define CLEAR_BYTE 8'h00
`endif

// >>> verif/decoder_model.sv
// Decoder stand-in issuing resolve requests {valid, short, pair, addr}.
// Assumes requests are taken on the rising edge.
`timescale 1ns/1ps
module decoder_model (
  input wire clk_i,
  output logic [10:0] req_o = 0
);
  // Hold one request over an edge, then scramble released fields
  task issue(input logic [10:0] r);
    @(negedge clk_i);
    req_o = r; // Common area named only in working form
    @(negedge clk_i);
    req_o = ~r & 11'h3ff;
  endtask
endmodule

// >>> verif/slice_ptr_monitor.sv
// Port checker for the slice pointer unit.
// Assumes a bind onto that unit.
`timescale 1ns/1ps
module slice_ptr_monitor (
  input wire clk_i, reset_n_i, reg_wr_i, op_valid_i, op_is_short_i, op_pair_i, op_valid_o, op_is_wreg_o,
  input wire [1:0] set_op_i,
  input wire [7:0] set_imm_i, op_addr_i, op_addr_o, op_addr_lo_o, first_slice_pointer_o, second_slice_pointer_o
);
  wire [7:0] f = first_slice_pointer_o;
  wire [7:0] s = second_slice_pointer_o;
  logic [7:0] want;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Slice address, low pointer bits unused
  always @(posedge clk_i) want <= {op_addr_i[3] ? s[7:3] : f[7:3], op_addr_i[2:0]};
  chk_reset_value: assert property ($rose(reset_n_i) |-> f == 8'hc0 && s == 8'hc8)
    else $error("reset value");
  chk_set_both: assert property (set_op_i == 2'h1 |=> f == $past(set_imm_i) && s == $past(set_imm_i) + 8'h08)
    else $error("set both");
  chk_set_first: assert property (set_op_i == 2'h2 |=> f == $past(set_imm_i) && s == $past(s))
    else $error("set first");
  chk_set_second: assert property (set_op_i == 2'h3 |=> s == $past(set_imm_i) && f == $past(f))
    else $error("set second");
  chk_hold_ptrs: assert property (set_op_i == 2'h0 && !reg_wr_i |=> $stable(f) && $stable(s))
    else $error("pointer moved");
  chk_wreg_addr:
    assert property (op_valid_i && !op_pair_i && (op_is_short_i || op_addr_i[7:4] == 4'hc)
    |=> op_addr_o == want && op_is_wreg_o) else $error("slice address");
  chk_plain_addr:
    assert property (op_valid_i && !op_pair_i && !op_is_short_i && op_addr_i[7:4] != 4'hc
    |=> op_addr_o == $past(op_addr_i) && !op_is_wreg_o) else $error("plain address");
  chk_pair_order: assert property (op_valid_o && $past(op_pair_i) |-> !op_addr_o[0] && op_addr_lo_o == op_addr_o + 8'h01)
    else $error("pair order");
endmodule
bind slice_pointer_unit slice_ptr_monitor i_mon (.clk_i, .reset_n_i, .reg_wr_i, .op_valid_i, .op_is_short_i,
  .op_pair_i, .op_valid_o, .op_is_wreg_o, .set_op_i, .set_imm_i, .op_addr_i, .op_addr_o, .op_addr_lo_o,
  .first_slice_pointer_o, .second_slice_pointer_o);

// >>> verif/tb.sv
// Self-checking bench for the slice pointer unit.
// Assumes the decoder model and the bound checker.
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, op_is_wreg_o;
  logic reg_rhit_o, op_valid_o, op_set1_o, op_bad_mode_o;
  logic [1:0] set_op_i = 0;
  logic [7:0] set_imm_i = 0, reg_addr_i = 0, reg_rdata_o, op_addr_o, op_addr_lo_o, f, s;
  logic [10:0] req;
  int fail_count = 0, checked = 0;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  decoder_model i_dec (.clk_i, .req_o(req));
  slice_pointer_unit i_dut (.clk_i, .reset_n_i, .set_op_i, .set_imm_i, .reg_wr_i, .reg_addr_i,
    .reg_wdata_i(set_imm_i), .reg_rd_i, .reg_rdata_o, .reg_rhit_o, .op_valid_i(req[10]), .op_is_short_i(req[9]),
    .op_pair_i(req[8]), .op_addr_i(req[7:0]), .op_valid_o, .op_addr_o, .op_addr_lo_o, .op_is_wreg_o,
    .op_set1_o, .op_bad_mode_o, .first_slice_pointer_o(f), .second_slice_pointer_o(s));
  task check(input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("%0d mismatches in %0d checks", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Inputs held until the next call, so strobes never toggle twice per step
  task step(input logic [1:0] op, input logic w, r, input logic [7:0] ad, d);
    @(negedge clk_i);
    {set_op_i, reg_wr_i, reg_rd_i, reg_addr_i, set_imm_i} = {op, w, r, ad, d};
  endtask
  task res(input logic [10:0] r, input logic [7:0] exp);
    i_dec.issue(r);
    check(op_addr_o, exp);
    check(op_valid_o, 1'h1);
    check(op_set1_o, exp >= 8'hc0);
    check(op_bad_mode_o, 1'h0);
  endtask
  task t_reset;
    check({f, s}, 16'hc0c8);
    check(op_valid_o, 1'h0);
    step(0, 0, 1, 8'hd7, 0);
    step(0, 0, 0, 0, 0);
    check(reg_rdata_o, 8'hc8);
    check(reg_rhit_o, 1'h1);
    res(11'h60a, 8'hca);
  endtask
  // Back-to-back set instructions, then a wrapping combined set
  task t_set;
    step(1, 0, 0, 0, 8'h70);
    step(3, 0, 0, 0, 8'h48);
    check({f, s}, 16'h7078);
    step(2, 0, 0, 0, 8'ha0);
    step(1, 0, 0, 0, 8'hfc);
    check({f, s}, 16'ha048);
    step(0, 0, 0, 0, 0);
    check({f, s}, 16'hfc04);
  endtask
  // Clear, load, write lost to a set op, write elsewhere
  task t_write;
    step(0, 1, 0, 8'hd6, 0);
    step(0, 1, 0, 8'hd7, 8'hf8);
    step(2, 1, 0, 8'hd7, 8'h33);
    check({f, s}, 16'h00f8);
    step(0, 1, 0, 8'hd5, 8'h11);
    step(0, 0, 1, 8'hd6, 0);
    step(0, 0, 1, 8'hd5, 0);
    check(reg_rdata_o, 8'h33);
    check(reg_rhit_o, 1'h1);
    step(0, 0, 0, 0, 0);
    check({f, s}, 16'h33f8);
    check({reg_rhit_o, reg_rdata_o}, 9'h000);
  endtask
  // Mid-run reset with pointers moved: defaults return, outputs clear
  task t_rereset;
    step(0, 0, 0, 0, 0);
    reset_n_i = 0;
    repeat (3) @(negedge clk_i);
    reset_n_i = 1;
    check({f, s}, 16'hc0c8);
    check(op_valid_o, 1'h0);
    res(11'h600, 8'hc0);
  endtask
  task t_res;
    res(11'h606, 8'h36);
    res(11'h60e, 8'hfe);
    res(11'h4cb, 8'hfb);
    check(op_is_wreg_o, 1'b1);
    res(11'h485, 8'h85);
    res(11'h705, 8'h34);
    check(op_addr_lo_o, 8'h35);
  endtask
  // Reset for ten cycles, then every scenario
  initial begin
    repeat (10) @(negedge clk_i);
    reset_n_i = 1;
    t_reset;
    t_set;
    t_write;
    t_res;
    t_rereset;
    complete_run;
  end
endmodule
